// *** fdcs_defines.vh ***
// Constants for the disk controller status block: offsets, fields, timing.
// Assumes inclusion by bare name from the design files; definitions only.
//
// Behaviour
// [R1] Main status bits 0..3 show, one per drive, that the drive is seeking.
// [R2] Main status bit 4 is high while a read or write command is in progress.
// [R3] Main status bit 5 is high only in a non-DMA execution phase; its fall ends that phase.
// [R4] Main status bit 6 is the direction: 1 byte for the processor, 0 processor writes.
// [R5] Main status bit 7 says the data register is ready; the processor uses it only then.
// [R6] First result status bits 1..0 hold the drive unit selected at the interrupt.
// [R7] First result status bit 2 holds the head selected at the interrupt.
// [R8] First result status bit 3 flags read/write to a not-ready drive or side 1 of a one-sided drive.
// [R9] First result status bit 4 flags a drive fault or 77 recalibrate steps without track zero.
// [R10] First result status bit 5 is set when a seek command completes.
// [R11] First result status bits 7..6 give termination: 00 normal, 01 abnormal, 10 invalid, 11 ready change.
// [R12] The size code is 0 for 128-byte and 1 for 256-byte sectors.
// [R13] Seven result bytes follow a command: status 0, 1, 2, cylinder, head, sector, size code.
// [R14] Result bytes are latched at command end and held until all seven are read.
// [R15] Second result status bit 4 flags the host missing a data transfer service interval.
`ifndef FDCS_DEFINES_VH
`define FDCS_DEFINES_VH

// Register byte offsets
`define FDCS_OFF_MAIN 8'h00
`define FDCS_OFF_DATA 8'h04
`define FDCS_OFF_IRQ_STAT 8'h08
`define FDCS_OFF_IRQ_MASK 8'h0C
`define FDCS_OFF_CTRL 8'h10
`define FDCS_OFF_RES0 8'h14

// Main status fields
`define FDCS_MS_BUSY 4
`define FDCS_MS_NONDMA 5
`define FDCS_MS_DIR 6
`define FDCS_MS_READY 7

// First result status fields
`define FDCS_ST0_HEAD 2
`define FDCS_ST0_NOTRDY 3
`define FDCS_ST0_FAULT 4
`define FDCS_ST0_SEEKEND 5
`define FDCS_TERM_NORMAL 2'h0
`define FDCS_TERM_ABNORMAL 2'h1
`define FDCS_TERM_INVALID 2'h2
`define FDCS_TERM_RDYCHG 2'h3

// Second result status overrun bit
`define FDCS_ST1_OVERRUN 4

// Sector size codes
`define FDCS_SIZE_128 8'h00
`define FDCS_SIZE_256 8'h01

// Recalibrate step limit
`define FDCS_RECAL_STEPS 7'd77

// Result bytes and service interval
`define FDCS_RESULT_BYTES 3'd7
`define FDCS_SERVICE_NS 13000
`define FDCS_CLK_NS 10
`define FDCS_SERVICE_CYC (`FDCS_SERVICE_NS / `FDCS_CLK_NS)

// Interrupt status bits
`define FDCS_IRQ_DONE 0
`define FDCS_IRQ_SEEK 1
`define FDCS_IRQ_OVERRUN 2

`endif

// *** fdcs_recal.v ***
// Recalibrate step counter: flags a fault after the step limit.
// Assumes step pulses and track-zero level synchronous to i_clock.
`timescale 1ns/1ps
`include "fdcs_defines.vh"
module fdcs_recal (
   input wire i_clock, // System clock
   input wire i_rst, // Async reset, active high
   input wire i_start, // Recalibrate begins
   input wire i_step, // One step pulse issued
   input wire i_track0, // Track zero seen
   output reg o_fail // Limit reached without track zero
);
   reg [6:0] steps_reg;
   reg active_reg;

   // Counting stops on track zero or limit
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         steps_reg <= 7'h00;
         active_reg <= 1'b0;
         o_fail <= 1'b0;
      end else if (i_start) begin
         steps_reg <= 7'h00;
         active_reg <= 1'b1;
         o_fail <= 1'b0;
      end else if (active_reg) begin
         if (i_track0) begin
            active_reg <= 1'b0;
         end else if (steps_reg >= `FDCS_RECAL_STEPS) begin
            active_reg <= 1'b0;
            o_fail <= 1'b1; // R9
         end else if (i_step) begin
            steps_reg <= steps_reg + 7'h01;
         end
      end else begin
         o_fail <= 1'b0; // One-cycle flag; the bank holds it until command end
      end
   end
endmodule

// *** fdcs_watchdog.v ***
// Service watchdog: flags an overrun when the host misses a byte window.
// Assumes a level that is high while a byte waits for the host.
`timescale 1ns/1ps
`include "fdcs_defines.vh"
module fdcs_watchdog #(
   parameter LIMIT = `FDCS_SERVICE_CYC // Cycles allowed per byte
) (
   input wire i_clock, // System clock
   input wire i_rst, // Async reset, active high
   input wire i_waiting, // Byte pending for host
   output reg o_overrun // One-cycle overrun pulse
);
   reg [15:0] count_reg;

   // Restart on every service; pulse once when window lapses
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         count_reg <= 16'h0000;
         o_overrun <= 1'b0;
      end else begin
         o_overrun <= 1'b0;
         if (!i_waiting) begin
            count_reg <= 16'h0000;
         end else if (count_reg == LIMIT[15:0] - 16'h0001) begin
            o_overrun <= 1'b1; // R15
            count_reg <= count_reg + 16'h0001;
         end else if (count_reg < LIMIT[15:0]) begin
            count_reg <= count_reg + 16'h0001;
         end
      end
   end
endmodule

// *** fdcs_status.v ***
// Status bank of a flexible disk controller with an AXI4-Lite slave.
// Assumes the command engine drives the i_ event and level inputs
// synchronously to i_clock; the host paces itself on the main status.
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "fdcs_defines.vh"
module fdcs_status (
   input wire i_clock, // 100 MHz clock
   input wire i_rst, // Async reset, active high
   // AXI4-Lite slave
   input wire [7:0] i_awaddr, // Write address
   input wire i_awvalid, // Write address valid
   output reg o_awready, // Write address ready
   input wire [31:0] i_wdata, // Write data
   input wire [3:0] i_wstrb, // Byte strobes
   input wire i_wvalid, // Write data valid
   output reg o_wready, // Write data ready
   output reg [1:0] o_bresp, // Write response
   output reg o_bvalid, // Write response valid
   input wire i_bready, // Write response ready
   input wire [7:0] i_araddr, // Read address
   input wire i_arvalid, // Read address valid
   output reg o_arready, // Read address ready
   output reg [31:0] o_rdata, // Read data
   output reg [1:0] o_rresp, // Read response
   output reg o_rvalid, // Read data valid
   input wire i_rready, // Read data ready
   // Command engine
   input wire [3:0] i_drive_seeking, // Per-drive seek activity
   input wire i_rw_active, // Read/write command running
   input wire i_exec_phase, // Execution phase running
   input wire i_data_byte_ready, // Engine byte ready for transfer
   input wire i_data_to_host, // Byte flows to the host
   input wire [7:0] i_exec_byte, // Byte from engine to host
   input wire i_cmd_end, // Command ends (pulse)
   input wire [1:0] i_unit, // Drive selected at end
   input wire i_head, // Head selected at end
   input wire i_drive_ready, // Drive ready level
   input wire i_single_sided, // Drive is single sided
   input wire i_fault, // Drive fault level
   input wire i_seek_done, // Seek completed (pulse)
   input wire [1:0] i_term, // Termination code
   input wire [7:0] i_st1, // Second result status from engine
   input wire [7:0] i_st2, // Third result status from engine
   input wire [7:0] i_cyl, // Cylinder number
   input wire [7:0] i_sector, // Sector number
   input wire i_size_256, // Sector is 256 bytes
   input wire i_recal_start, // Recalibrate starts
   input wire i_step, // Step pulse
   input wire i_track0, // Track zero level
   output reg o_host_took, // Host read/wrote exec data (pulse)
   output reg [7:0] o_host_byte, // Byte written by host
   output reg o_irq // Interrupt, active high level
);
   ////////////////////////////////////////////////////////////////////////
   // State
   reg [7:0] main_reg;
   reg [7:0] res_reg [0:6];
   reg [2:0] res_idx_reg;
   reg res_pend_reg;
   reg [2:0] irq_stat_reg;
   reg [2:0] irq_mask_reg;
   reg dma_mode_reg;
   reg overrun_seen_reg;
   reg recal_fail_reg;
   reg have_aw_reg;
   reg have_w_reg;
   reg [7:0] awaddr_reg;
   reg [31:0] wdata_reg;
   reg [3:0] wstrb_reg;
   wire recal_fail;
   wire overrun;
   wire [2:0] irq_set;
   wire wr_fire;
   wire rd_fire;
   wire data_rd;
   wire data_wr;
   integer i;

   // Status byte 0 from the live condition at command end
   function [7:0] fdcs_st0;
      input [1:0] term;
      input nrdy;
      input flt;
      input seek;
      input head;
      input [1:0] unit;
      begin
         fdcs_st0 = {term, seek, flt, nrdy, head, unit};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Helpers
   fdcs_recal u_recal (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_start(i_recal_start),
      .i_step(i_step),
      .i_track0(i_track0),
      .o_fail(recal_fail)
   );

   // Watch the host only while it must service a non-DMA byte
   fdcs_watchdog u_wdog (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_waiting(main_reg[`FDCS_MS_READY] & main_reg[`FDCS_MS_NONDMA]),
      .o_overrun(overrun)
   );

   ////////////////////////////////////////////////////////////////////////
   // Bus decode
   assign wr_fire = have_aw_reg & have_w_reg & ~o_bvalid;
   assign rd_fire = i_arvalid & o_arready;
   assign data_rd = rd_fire & (i_araddr == `FDCS_OFF_DATA);
   assign data_wr = wr_fire & (awaddr_reg == `FDCS_OFF_DATA) & wstrb_reg[0];
   assign irq_set = {overrun, i_seek_done, i_cmd_end};

   ////////////////////////////////////////////////////////////////////////
   // Main status: updated every cycle from engine state
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         main_reg <= 8'h00;
      end else begin
         main_reg[3:0] <= i_drive_seeking; // R1
         main_reg[`FDCS_MS_BUSY] <= i_rw_active; // R2
         main_reg[`FDCS_MS_NONDMA] <= i_exec_phase & ~dma_mode_reg; // R3
         // Direction: host reads results or exec bytes flowing out
         main_reg[`FDCS_MS_DIR] <= res_pend_reg | (i_exec_phase & i_data_to_host); // R4
         // Ready only when something is to move and it was not just moved
         main_reg[`FDCS_MS_READY] <= ~(data_rd | data_wr) &
            (res_pend_reg | (i_exec_phase & ~dma_mode_reg & i_data_byte_ready)); // R5
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Result bytes latched at command end, frozen until all are read
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         for (i = 0; i < 7; i = i + 1) begin
            res_reg[i] <= 8'h00;
         end
         res_idx_reg <= 3'h0;
         res_pend_reg <= 1'b0;
         overrun_seen_reg <= 1'b0;
         recal_fail_reg <= 1'b0;
      end else begin
         if (overrun) begin
            overrun_seen_reg <= 1'b1;
         end
         if (recal_fail) begin
            recal_fail_reg <= 1'b1;
         end
         if (i_cmd_end && !res_pend_reg) begin // R14
            res_reg[0] <= fdcs_st0(i_term, // R11
               i_rw_active & (~i_drive_ready | (i_head & i_single_sided)), // R8
               i_fault | recal_fail_reg | recal_fail, // R9
               i_seek_done, // R10
               i_head, // R7
               i_unit); // R6
            res_reg[1] <= i_st1 | ({7'h00, overrun_seen_reg | overrun}
               << `FDCS_ST1_OVERRUN); // R15
            res_reg[2] <= i_st2;
            res_reg[3] <= i_cyl;
            res_reg[4] <= {7'h00, i_head};
            res_reg[5] <= i_sector;
            res_reg[6] <= i_size_256 ? `FDCS_SIZE_256 : `FDCS_SIZE_128; // R12
            res_idx_reg <= 3'h0;
            res_pend_reg <= 1'b1;
            overrun_seen_reg <= 1'b0;
            recal_fail_reg <= 1'b0;
         end else if (data_rd && res_pend_reg && main_reg[`FDCS_MS_READY]) begin
            // Bytes leave in fixed order, then the set is released
            if (res_idx_reg == `FDCS_RESULT_BYTES - 3'h1) begin // R13
               res_pend_reg <= 1'b0;
               res_idx_reg <= 3'h0;
            end else begin
               res_idx_reg <= res_idx_reg + 3'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write channel: address and data taken in either order
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_awready <= 1'b1;
         o_wready <= 1'b1;
         have_aw_reg <= 1'b0;
         have_w_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
         o_bvalid <= 1'b0;
         o_bresp <= 2'h0;
      end else begin
         if (i_awvalid && o_awready) begin
            awaddr_reg <= i_awaddr;
            have_aw_reg <= 1'b1;
            o_awready <= 1'b0;
         end
         if (i_wvalid && o_wready) begin
            wdata_reg <= i_wdata;
            wstrb_reg <= i_wstrb;
            have_w_reg <= 1'b1;
            o_wready <= 1'b0;
         end
         if (wr_fire) begin
            have_aw_reg <= 1'b0;
            have_w_reg <= 1'b0;
            o_bvalid <= 1'b1;
            case (awaddr_reg)
               `FDCS_OFF_DATA, `FDCS_OFF_IRQ_STAT, `FDCS_OFF_IRQ_MASK, `FDCS_OFF_CTRL: begin
                  o_bresp <= 2'h0;
               end
               default: begin
                  o_bresp <= 2'h2; // Read-only or unmapped
               end
            endcase
         end
         if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control, mask, interrupt status; set wins over write-one-clear
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         irq_stat_reg <= 3'h0;
         irq_mask_reg <= 3'h0;
         dma_mode_reg <= 1'b0;
         o_irq <= 1'b0;
         o_host_took <= 1'b0;
         o_host_byte <= 8'h00;
      end else begin
         o_host_took <= 1'b0;
         if (wr_fire && wstrb_reg[0] && awaddr_reg == `FDCS_OFF_IRQ_STAT) begin
            irq_stat_reg <= (irq_stat_reg & ~wdata_reg[2:0]) | irq_set;
         end else begin
            irq_stat_reg <= irq_stat_reg | irq_set;
         end
         if (wr_fire && wstrb_reg[0] && awaddr_reg == `FDCS_OFF_IRQ_MASK) begin
            irq_mask_reg <= wdata_reg[2:0];
         end
         if (wr_fire && wstrb_reg[0] && awaddr_reg == `FDCS_OFF_CTRL) begin
            dma_mode_reg <= wdata_reg[0];
         end
         // Host byte accepted only when ready and direction is inward
         if (data_wr && main_reg[`FDCS_MS_READY] && !main_reg[`FDCS_MS_DIR]) begin // R5
            o_host_took <= 1'b1;
            o_host_byte <= wdata_reg[7:0];
         end
         if (data_rd && main_reg[`FDCS_MS_READY] && !res_pend_reg) begin
            o_host_took <= 1'b1;
         end
         o_irq <= |((irq_stat_reg | irq_set) & irq_mask_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read channel: one-cycle answer after address taken
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_arready <= 1'b1;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h00000000;
         o_rresp <= 2'h0;
      end else begin
         if (rd_fire) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rresp <= 2'h0;
            case (i_araddr)
               `FDCS_OFF_MAIN: o_rdata <= {24'h000000, main_reg};
               `FDCS_OFF_DATA: begin
                  // Result set first, else the live engine byte
                  o_rdata <= {24'h000000, res_pend_reg ? res_reg[res_idx_reg] : i_exec_byte};
               end
               `FDCS_OFF_IRQ_STAT: o_rdata <= {29'h00000000, irq_stat_reg};
               `FDCS_OFF_IRQ_MASK: o_rdata <= {29'h00000000, irq_mask_reg};
               `FDCS_OFF_CTRL: o_rdata <= {31'h00000000, dma_mode_reg};
               `FDCS_OFF_RES0: o_rdata <= {24'h000000, res_reg[0]};
               default: begin
                  o_rdata <= 32'h00000000;
                  o_rresp <= 2'h2;
               end
            endcase
         end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
         end
      end
   end
endmodule

// *** fdcs_status_props.sv ***
// Checker: bus handshakes and main status bits.
// Assumes binding to fdcs_status; sees its ports only.
`timescale 1ns/1ps
module fdcs_status_props (
   input wire i_clock, // Clock
   input wire i_rst, // Async reset
   input wire [7:0] i_awaddr, // Write address
   input wire i_awvalid, // Write address valid
   input wire o_awready, // Write address ready
   input wire i_wvalid, // Write data valid
   input wire o_wready, // Write data ready
   input wire [1:0] o_bresp, // Write response
   input wire o_bvalid, // Write response valid
   input wire i_bready, // Write response ready
   input wire [7:0] i_araddr, // Read address
   input wire i_arvalid, // Read address valid
   input wire o_arready, // Read address ready
   input wire [31:0] o_rdata, // Read data
   input wire o_rvalid, // Read data valid
   input wire i_rready, // Read data ready
   input wire [3:0] i_drive_seeking, // Seek levels
   input wire i_rw_active, // Read/write running
   input wire i_exec_phase // Execution phase
);
////////////////////////////////////////////////////////////////////////////////
   reg [7:0] ar_q;
   reg [7:0] aw_q;
   // Addresses of the last taken requests
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         ar_q <= 8'h00;
         aw_q <= 8'h00;
      end else begin
         if (i_arvalid && o_arready) ar_q <= i_araddr;
         if (i_awvalid && o_awready) aw_q <= i_awaddr;
      end
   end
////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   sequence s_ar_take; i_arvalid && o_arready; endsequence
   sequence s_wr_take; i_awvalid && o_awready && i_wvalid && o_wready; endsequence
   // Main status answer with inputs steady two cycles
   sequence s_main_ans; $rose(o_rvalid) && ar_q == 8'h00; endsequence
   AST_SEEK_BITS: assert property (s_main_ans ##0 $stable(i_drive_seeking) ##0
      ($past(i_drive_seeking, 2) == i_drive_seeking) |-> o_rdata[3:0] == i_drive_seeking)
      else $error("seek flags wrong");
   AST_BUSY_BIT: assert property (s_main_ans ##0 $stable(i_rw_active) ##0
      ($past(i_rw_active, 2) == i_rw_active) |-> o_rdata[4] == i_rw_active)
      else $error("busy bit wrong");
   AST_NONDMA: assert property (s_main_ans ##0 o_rdata[5] |->
      $past(i_exec_phase, 1) || $past(i_exec_phase, 2))
      else $error("non-DMA bit outside execution");
   AST_RD_ANSWER: assert property (s_ar_take |=> o_rvalid)
      else $error("read answer late");
   AST_RD_HOLD: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read answer not held");
   AST_WR_ANSWER: assert property (s_wr_take |-> ##[1:2] o_bvalid)
      else $error("write response late");
   AST_BV_HOLD: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response not held");
   AST_RO_MAIN: assert property ($rose(o_bvalid) && aw_q == 8'h00 |-> o_bresp == 2'h2)
      else $error("write to main status not refused");
endmodule
bind fdcs_status fdcs_status_props u_props (.i_clock(i_clock), .i_rst(i_rst),
   .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid),
   .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
   .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
   .o_rvalid(o_rvalid), .i_rready(i_rready), .i_drive_seeking(i_drive_seeking),
   .i_rw_active(i_rw_active), .i_exec_phase(i_exec_phase));

// *** fdcs_host_model.sv ***
// Host model: bus master paced by main status.
// Assumes the bank's clock; the bench times out hangs.
`timescale 1ns/1ps
module fdcs_host_model (
   input wire i_clock, // Clock
   output reg [7:0] o_awaddr, // Write address
   output reg o_awvalid = 1'b0, // Write address valid
   input wire i_awready, // Write address ready
   output reg [31:0] o_wdata, // Write data
   output reg [3:0] o_wstrb, // Byte strobes
   output reg o_wvalid = 1'b0, // Write data valid
   input wire i_wready, // Write data ready
   input wire [1:0] i_bresp, // Write response
   input wire i_bvalid, // Write response valid
   output reg o_bready = 1'b0, // Write response ready
   output reg [7:0] o_araddr, // Read address
   output reg o_arvalid = 1'b0, // Read address valid
   input wire i_arready, // Read address ready
   input wire [31:0] i_rdata, // Read data
   input wire [1:0] i_rresp, // Read response
   input wire i_rvalid, // Read data valid
   output reg o_rready = 1'b0 // Read data ready
);
////////////////////////////////////////////////////////////////////////////////
   // Write: both offered, each released when taken
   task wr(input [7:0] a, input [31:0] dt, output [1:0] rs);
      reg done;
      begin
         done = 1'b0;
         @(posedge i_clock);
         o_awaddr <= a; o_awvalid <= 1'b1; o_wdata <= dt; o_wstrb <= 4'hF;
         o_wvalid <= 1'b1; o_bready <= 1'b1;
         while (!done) begin
            @(posedge i_clock);
            if (o_awvalid && i_awready) o_awvalid <= 1'b0;
            if (o_wvalid && i_wready) o_wvalid <= 1'b0;
            if (i_bvalid) begin
               rs = i_bresp; o_bready <= 1'b0; done = 1'b1;
            end
         end
      end
   endtask
   // Read: address held until taken
   task rd(input [7:0] a, output [31:0] dt, output [1:0] rs);
      reg done;
      begin
         done = 1'b0;
         @(posedge i_clock);
         o_araddr <= a; o_arvalid <= 1'b1; o_rready <= 1'b1;
         while (!done) begin
            @(posedge i_clock);
            if (o_arvalid && i_arready) o_arvalid <= 1'b0;
            if (i_rvalid) begin
               dt = i_rdata; rs = i_rresp; o_rready <= 1'b0; done = 1'b1;
            end
         end
      end
   endtask
   // Data access only when ready, in the shown direction
   task xfer(input [7:0] wb, output [7:0] rb);
      reg [31:0] m;
      reg [1:0] rr;
      begin
         m = 32'h0;
         while (!m[7]) rd(8'h00, m, rr);
         if (m[6]) begin
            rd(8'h04, m, rr);
            rb = m[7:0];
         end else begin
            wr(8'h04, {24'h0, wb}, rr);
            rb = wb;
         end
      end
   endtask
endmodule

// *** testbench.sv ***
// Self-checking bench for the status bank.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps
module testbench;
   reg i_clock = 1'b0;
   reg i_rst = 1'b1;
   reg [3:0] seek = 4'h0;
   reg rw = 1'b0, xph = 1'b0, brdy = 1'b0, to_host = 1'b0, cend = 1'b0, head = 1'b0;
   reg drdy = 1'b1, ss = 1'b0, flt = 1'b0, sdone = 1'b0, rstart = 1'b0, step = 1'b0;
   reg trk0 = 1'b0, s256 = 1'b0;
   reg [1:0] unit = 2'h0, term = 2'h0;
   reg [7:0] xbyte = 8'h00, st1 = 8'h00, st2 = 8'h00, cyl = 8'h00, sec = 8'h00, b;
   reg [7:0] ex [0:6];
   reg [31:0] d;
   reg [1:0] r;
   wire [7:0] awaddr, araddr, hbyte;
   wire [31:0] wdata, rdata;
   wire [3:0] wstrb;
   wire [1:0] bresp, rresp;
   wire awvalid, awready, wvalid, wready, bvalid, bready;
   wire arvalid, arready, rvalid, rready, took, irq;
   integer err_count = 0, cmp_count = 0, cycles = 0, took_n = 0, k, j;
////////////////////////////////////////////////////////////////////////////////
   initial forever #5 i_clock = ~i_clock;
   fdcs_host_model u_host (.i_clock(i_clock), .o_awaddr(awaddr), .o_awvalid(awvalid),
      .i_awready(awready), .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid),
      .i_wready(wready), .i_bresp(bresp), .i_bvalid(bvalid), .o_bready(bready),
      .o_araddr(araddr), .o_arvalid(arvalid), .i_arready(arready), .i_rdata(rdata),
      .i_rresp(rresp), .i_rvalid(rvalid), .o_rready(rready));
   fdcs_status DUT (.i_clock(i_clock), .i_rst(i_rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
      .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
      .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
      .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
      .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_drive_seeking(seek),
      .i_rw_active(rw), .i_exec_phase(xph), .i_data_byte_ready(brdy),
      .i_data_to_host(to_host), .i_exec_byte(xbyte), .i_cmd_end(cend), .i_unit(unit),
      .i_head(head), .i_drive_ready(drdy), .i_single_sided(ss), .i_fault(flt),
      .i_seek_done(sdone), .i_term(term), .i_st1(st1), .i_st2(st2), .i_cyl(cyl),
      .i_sector(sec), .i_size_256(s256), .i_recal_start(rstart), .i_step(step),
      .i_track0(trk0), .o_host_took(took), .o_host_byte(hbyte), .o_irq(irq));
////////////////////////////////////////////////////////////////////////////////
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task close_out;
      begin
         if (err_count == 0 && cmp_count > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge i_clock);
   endtask
   // Hang guard; the run needs well under 20000 cycles
   always @(posedge i_clock) begin
      cycles <= cycles + 1;
      if (took) took_n <= took_n + 1;
      if (cycles == 20000) begin
         err_count = err_count + 1;
         close_out;
      end
   end
////////////////////////////////////////////////////////////////////////////////
   initial begin
      tick(5);
      i_rst <= 1'b0;
      // One drive seeking at a time
      for (k = 0; k < 4; k = k + 1) begin
         seek <= 4'h1 << k; rw <= k[0]; tick(1);
         u_host.rd(8'h00, d, r); chk(d[4:0], {k[0], 4'h1 << k});
      end
      // Refused writes and reads
      u_host.wr(8'h00, 32'hFF, r); chk(r, 2'h2);
      u_host.rd(8'h20, d, r); chk(r, 2'h2);
      // Non-DMA: one byte out, one in
      seek <= 4'h0; rw <= 1'b1; xph <= 1'b1; brdy <= 1'b1; to_host <= 1'b1; xbyte <= 8'hC3;
      u_host.wr(8'h10, 32'h0, r); u_host.rd(8'h00, d, r); chk(d[7:4], 4'hF);
      u_host.xfer(8'h00, b); chk(b, 8'hC3);
      to_host <= 1'b0; u_host.xfer(8'h5A, b); tick(2); chk(hbyte, 8'h5A);
      chk(took_n, 2);
      // DMA mode clears bit 5
      u_host.wr(8'h10, 32'h1, r); u_host.rd(8'h00, d, r); chk(d[5], 1'b0);
      u_host.wr(8'h10, 32'h0, r); xph <= 1'b0; brdy <= 1'b0;
      u_host.wr(8'h0C, 32'h1, r);
      // Every termination code
      for (k = 0; k < 4; k = k + 1) begin
         unit <= k[1:0]; term <= k[1:0]; head <= k[0]; drdy <= (k != 3); ss <= (k == 1);
         flt <= (k == 2); s256 <= k[0]; cyl <= 8'h10 + k; sec <= 8'h20 + k;
         st1 <= 8'h01 << k; st2 <= 8'h80 >> k;
         ex[0] = {k[1:0], k == 0, k == 2, k == 1 || k == 3, k[0], k[1:0]};
         ex[1] = (8'h01 << k) | ((k == 1) ? 8'h10 : 8'h00); ex[2] = 8'h80 >> k;
         ex[3] = 8'h10 + k; ex[4] = k[0]; ex[5] = 8'h20 + k; ex[6] = k[0];
         // Host misses the service interval
         if (k == 1) begin
            xph <= 1'b1; brdy <= 1'b1; to_host <= 1'b1; tick(1320);
            xph <= 1'b0; brdy <= 1'b0;
         end
         tick(1); cend <= 1'b1; sdone <= (k == 0); tick(1); cend <= 1'b0; sdone <= 1'b0;
         cyl <= 8'hEE; sec <= 8'hEE; st1 <= 8'h00; st2 <= 8'h00;
         tick(3); chk(irq, 1'b1);
         for (j = 0; j < 7; j = j + 1) begin
            u_host.xfer(8'h00, b); chk(b, ex[j]);
         end
         u_host.wr(8'h08, 32'h7, r); tick(2); chk(irq, 1'b0);
      end
      // Masked event stays quiet
      u_host.wr(8'h0C, 32'h0, r); tick(1); sdone <= 1'b1; tick(1); sdone <= 1'b0;
      tick(3); chk(irq, 1'b0); u_host.rd(8'h08, d, r); chk(d[1], 1'b1);
      u_host.wr(8'h0C, 32'h2, r); tick(2); chk(irq, 1'b1);
      u_host.wr(8'h08, 32'h2, r); tick(2); chk(irq, 1'b0);
      // Recalibrate limit, no track zero
      term <= 2'h0; unit <= 2'h0; head <= 1'b0; flt <= 1'b0; drdy <= 1'b1; ss <= 1'b0;
      rstart <= 1'b1; tick(1); rstart <= 1'b0;
      for (j = 0; j < 77; j = j + 1) begin
         step <= 1'b1; tick(1); step <= 1'b0; tick(1);
      end
      tick(2); cend <= 1'b1; tick(1); cend <= 1'b0;
      u_host.xfer(8'h00, b); chk(b, 8'h10);
      close_out;
   end
endmodule
